// [pmirq_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the runtime register bank.
// Assumes: Register index times four is the Wishbone byte address.
// Notes: Overview list below names the status, delay, routing and force behaviours; ring wake is not listed.
// Overview of operation
// - UART 1 receive falling edge sets bit 0.
// - UART 2 receive falling edge sets bit 1.
// - Ring pin event sets bit 3, clear on read.
// - Button press sets bit 2; not power-down source.
// - Delay code selects 500 ms steps, 500ms..32s.
// - Each delay lasts nominal to nominal plus 10ms.
// - Button starts delay when enabled and option set.
// - Bit 0 picks serial or parallel interrupts.
// - Parallel mode disables BIOS buffer, pins become IRQ15/14.
// - Bit 2 routes control interrupt frame or pin.
// - Bit 3 sets control interrupt polarity.
// - Bit 4 sets push-pull or open drain.
// - Bits 6:5 pick shared pin function.
// - Bit 5 overrides configured control interrupt number.
// - Shared pin buffer type follows its function.
// - Bit 7 routes management interrupt frame or pin.
// - Management pin polarity, buffer from config; OD low default.
// - Force bits set by software, cleared by step+select.
// - Disk change equals selected forces OR input.
// - Force bit makes disk change active for drive.
// - Status bit reads 1 once event occurred.
// - Force bit 0 drive 0, bit 1 drive 1.
`ifndef PMIRQ_CONSTS_SVH
`define PMIRQ_CONSTS_SVH
`define PMIRQ_ADR_W         10
`define PMIRQ_IDX_STATUS2   8'hB3
`define PMIRQ_IDX_DELAY     8'hB8
`define PMIRQ_IDX_ROUTE     8'hC0
`define PMIRQ_IDX_FORCE     8'hC1
`define PMIRQ_IDX_CTRL      8'hD0
`define PMIRQ_RST_DELAY     6'h00
`define PMIRQ_RST_ROUTE     8'h00
`define PMIRQ_RST_FORCE     2'h3
`define PMIRQ_RST_CTRL      5'h01
// Edge pins idle high, floppy levels idle low, so a reset neither fakes an event nor clears a force bit.
`define PMIRQ_RST_PINS      8'h0F
`define PMIRQ_ST_UART1      0
`define PMIRQ_ST_UART2      1
`define PMIRQ_ST_BUTTON     2
`define PMIRQ_ST_RING       3
`define PMIRQ_RT_PARALLEL   0
`define PMIRQ_RT_SCI_PIN    2
`define PMIRQ_RT_SCI_POL    3
`define PMIRQ_RT_SCI_OD     4
`define PMIRQ_RT_SHARED_LO  5
`define PMIRQ_RT_SHARED_HI  6
`define PMIRQ_RT_SMI_PIN    7
`define PMIRQ_CT_OFF_EN     0
`define PMIRQ_CT_POWEROFF_DELAY_OPTION    1
`define PMIRQ_CT_SMI_POL    2
`define PMIRQ_CT_SMI_PP     3
`define PMIRQ_CT_RING_WAKE  4
`define PMIRQ_CT_RUNNING    7
`define PMIRQ_PIN_UART1     0
`define PMIRQ_PIN_UART2     1
`define PMIRQ_PIN_BUTTON    2
`define PMIRQ_PIN_RING      3
`define PMIRQ_PIN_STEP      4
`define PMIRQ_PIN_DS0       5
`define PMIRQ_PIN_DS1       6
`define PMIRQ_PIN_DSKCHG    7
`define PMIRQ_CLK_KHZ       125000
`define PMIRQ_TICK_US       10000
`define PMIRQ_STEP_MS       500
`define PMIRQ_TICK_CYCLES   ((`PMIRQ_CLK_KHZ * `PMIRQ_TICK_US) / 1000)
`define PMIRQ_TICKS_PER_STEP ((`PMIRQ_STEP_MS * 1000) / `PMIRQ_TICK_US)
`endif

// [pmirq_host_model.sv]
// Purpose: Host bus master issuing classic Wishbone single cycles.
// Assumes: Register index times four is the byte address.
// Notes: Released address and data are inverted so stale values are never trusted.
`include "pmirq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module pmirq_host_model
(
	input  wire logic                    ref_clk,
	output logic                         wb_cyc_i,
	output logic                         wb_stb_i,
	output logic                         wb_we_i,
	output logic [`PMIRQ_ADR_W-1:0]      wb_adr_i,
	output logic [3:0]                   wb_sel_i,
	output logic [31:0]                  wb_dat_i,
	input  wire logic [31:0]             wb_dat_o,
	input  wire logic                    wb_ack_o
);
	initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
	task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hF;
		wb_dat_i <= {24'h000000, d};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= ~{idx, 2'b00};
		wb_dat_i <= ~{24'h000000, d};
	endtask : xfer
endmodule : pmirq_host_model
`default_nettype wire

// [pmirq_pkg.sv]
// Purpose: Types shared by the runtime register bank.
// Assumes: Nothing beyond the constants header.
// Notes: Encodings of the shared pin select and timer state.
`default_nettype none
package pmirq_pkg;
	typedef logic [7:0] pmirq_byte_t;
	typedef enum logic [1:0]
	{
		PMIRQ_SHARED_PME = 2'b00,
		PMIRQ_SHARED_SCI = 2'b01,
		PMIRQ_SHARED_IRQ9 = 2'b10,
		PMIRQ_SHARED_RSVD = 2'b11
	} pmirq_shared_e;
	typedef enum logic
	{
		PMIRQ_TMR_IDLE = 1'b0,
		PMIRQ_TMR_RUN = 1'b1
	} pmirq_tmr_e;
endpackage : pmirq_pkg
`default_nettype wire

// [pmirq_runtime_regs.sv]
// Purpose: Runtime wake status, power-off delay, interrupt routing and forced disk change.
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low byte.
// Notes: Every output is a field of the registered state.
//
// Added by the designer: register access over Wishbone.
`include "pmirq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module pmirq_runtime_regs
#(
	parameter int TICK_CYCLES    = `PMIRQ_TICK_CYCLES,
	parameter int TICKS_PER_STEP = `PMIRQ_TICKS_PER_STEP
)
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [`PMIRQ_ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic                      uart1ReceivePin,
	input  wire logic                      uart2ReceivePin,
	input  wire logic                      powerButtonPin_n,
	input  wire logic                      ringIndicatePin_n,
	input  wire logic                      floppyStepSignal,
	input  wire logic                      driveSelectZero,
	input  wire logic                      driveSelectOne,
	input  wire logic                      diskChangeInput,
	input  wire logic                      sciRequest,
	input  wire logic                      smiRequest,
	input  wire logic                      pmeRequest,
	input  wire logic                      irq9Request,
	input  wire logic                      irq14Request,
	input  wire logic                      irq15Request,
	input  wire logic [3:0]                sciConfigIrq,
	output logic                           powerOnOutput,
	output logic                           powerOffRequest,
	output logic                           diskChangeFlag,
	output logic [1:0]                     forceDiskChange,
	output logic                           biosBufferEnable,
	output logic                           serialIrqEnable,
	output logic                           sciSerialRequest,
	output logic                           smiSerialRequest,
	output logic                           sciIrqOverride,
	output logic [3:0]                     sciIrqNumber,
	output logic                           sharedPinOut,
	output logic                           sharedPinOe_n,
	output logic                           sciIrqPinOut,
	output logic                           sciIrqPinOe_n,
	output logic                           managementInterruptPinOut,
	output logic                           managementInterruptPinOe_n,
	output logic                           irq15PinOut,
	output logic                           irq15PinOe_n,
	output logic                           irq14PinOut,
	output logic                           irq14PinOe_n
);
	import pmirq_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);

	generate
		if (TICK_CYCLES < 1 || TICKS_PER_STEP < 1 || 64 * TICKS_PER_STEP > 4095)
		begin : g_bad_timing
			$error("Delay timing parameters out of range.");
		end
	endgenerate

	typedef struct packed {
		logic              ack;
		pmirq_byte_t       dat;
		logic [5:0]        delaySel;
		pmirq_byte_t       route;
		logic [1:0]        forceBits;
		logic [4:0]        ctrl;
		logic [3:0]        status;
		logic [7:0]        sync1;
		logic [7:0]        sync2;
		logic [7:0]        prev;
		pmirq_tmr_e        tmr;
		logic [TW-1:0]     tickCnt;
		logic [11:0]       stepCnt;
		logic              powerOn;
		logic              powerOff;
		logic              dskChg;
		logic              biosEn;
		logic              serEn;
		logic              sciSer;
		logic              smiSer;
		logic              sciOvr;
		logic [3:0]        sciNum;
		logic [1:0]        shared;
		logic [1:0]        sciPin;
		logic [1:0]        smiPin;
		logic [1:0]        irq15Pin;
		logic [1:0]        irq14Pin;
	} pmirq_state_s;

	pmirq_state_s stateReg;
	pmirq_state_s stateNext;

	// Returns {out, oe_n}; open drain only ever pulls low, so a high level releases the pin.
	function automatic logic [1:0] padDrive(input logic active, input logic activeHigh,
		input logic openDrain);
		logic level;
		level = activeHigh ? active : ~active;
		if (openDrain)
			padDrive = {1'b0, level};
		else
			padDrive = {level, 1'b0};
	endfunction : padDrive

	function automatic logic isReg(input logic [7:0] idx, input logic [7:0] want);
		isReg = (idx == want);
	endfunction : isReg

	always_comb
	begin
		logic [7:0]  pinVec;
		logic [7:0]  fall;
		logic [7:0]  idx;
		logic        hit;
		logic        take;
		logic        wr;
		logic [3:0]  events;
		logic [3:0]  clrMask;
		logic        buttonEv;
		logic        stepDs0;
		logic        stepDs1;
		logic [11:0] target;
		logic [1:0]  setForce;
		pmirq_shared_e sharedSel;
		pinVec = 8'h00;
		fall = 8'h00;
		idx = 8'h00;
		hit = 1'b0;
		take = 1'b0;
		wr = 1'b0;
		events = 4'h0;
		clrMask = 4'h0;
		buttonEv = 1'b0;
		stepDs0 = 1'b0;
		stepDs1 = 1'b0;
		target = 12'h000;
		setForce = 2'h0;
		sharedSel = PMIRQ_SHARED_PME;
		stateNext = stateReg;

		// Pins are asynchronous; the first stage feeds only the second.
		pinVec[`PMIRQ_PIN_UART1] = uart1ReceivePin;
		pinVec[`PMIRQ_PIN_UART2] = uart2ReceivePin;
		pinVec[`PMIRQ_PIN_BUTTON] = powerButtonPin_n;
		pinVec[`PMIRQ_PIN_RING] = ringIndicatePin_n;
		pinVec[`PMIRQ_PIN_STEP] = floppyStepSignal;
		pinVec[`PMIRQ_PIN_DS0] = driveSelectZero;
		pinVec[`PMIRQ_PIN_DS1] = driveSelectOne;
		pinVec[`PMIRQ_PIN_DSKCHG] = diskChangeInput;
		stateNext.sync1 = pinVec;
		stateNext.sync2 = stateReg.sync1;
		stateNext.prev = stateReg.sync2;
		fall = stateReg.prev & ~stateReg.sync2;

		events[`PMIRQ_ST_UART1] = fall[`PMIRQ_PIN_UART1];
		events[`PMIRQ_ST_UART2] = fall[`PMIRQ_PIN_UART2];
		buttonEv = fall[`PMIRQ_PIN_BUTTON];
		events[`PMIRQ_ST_BUTTON] = buttonEv;
		events[`PMIRQ_ST_RING] = fall[`PMIRQ_PIN_RING];

		// Bus: ack one cycle after the request, effects at the edge that samples ack.
		hit = wb_cyc_i & wb_stb_i;
		take = hit & stateReg.ack;
		wr = take & wb_we_i & wb_sel_i[0];
		idx = wb_adr_i[`PMIRQ_ADR_W-1:2];
		stateNext.ack = hit & ~stateReg.ack;
		if (hit & ~stateReg.ack)
		begin
			if (isReg(idx, `PMIRQ_IDX_STATUS2))
				stateNext.dat = {4'h0, stateReg.status};
			else if (isReg(idx, `PMIRQ_IDX_DELAY))
				stateNext.dat = {2'b00, stateReg.delaySel};
			else if (isReg(idx, `PMIRQ_IDX_ROUTE))
				stateNext.dat = stateReg.route;
			else if (isReg(idx, `PMIRQ_IDX_FORCE))
				stateNext.dat = {6'h00, stateReg.forceBits};
			else if (isReg(idx, `PMIRQ_IDX_CTRL))
				stateNext.dat = {(stateReg.tmr == PMIRQ_TMR_RUN), 2'b00, stateReg.ctrl};
			else
				stateNext.dat = 8'h00;
		end

		// Only the bits actually returned are cleared, so a later event survives.
		if (take & ~wb_we_i & isReg(idx, `PMIRQ_IDX_STATUS2))
			clrMask = stateReg.dat[3:0];
		stateNext.status = (stateReg.status & ~clrMask) | events;

		if (wr & isReg(idx, `PMIRQ_IDX_DELAY))
			stateNext.delaySel = wb_dat_i[5:0];
		if (wr & isReg(idx, `PMIRQ_IDX_ROUTE))
			stateNext.route = {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
		if (wr & isReg(idx, `PMIRQ_IDX_CTRL))
			stateNext.ctrl = wb_dat_i[4:0];
		if (wr & isReg(idx, `PMIRQ_IDX_FORCE))
			setForce = wb_dat_i[1:0];

		// Software can only set; the step and select pair clears, and a set wins.
		stepDs0 = stateReg.sync2[`PMIRQ_PIN_STEP] & stateReg.sync2[`PMIRQ_PIN_DS0];
		stepDs1 = stateReg.sync2[`PMIRQ_PIN_STEP] & stateReg.sync2[`PMIRQ_PIN_DS1];
		stateNext.forceBits[0] = setForce[0] | (stateReg.forceBits[0] & ~stepDs0);
		stateNext.forceBits[1] = setForce[1] | (stateReg.forceBits[1] & ~stepDs1);
		stateNext.dskChg = (stateReg.sync2[`PMIRQ_PIN_DS0] & stateReg.forceBits[0])
			| (stateReg.sync2[`PMIRQ_PIN_DS1] & stateReg.forceBits[1])
			| stateReg.sync2[`PMIRQ_PIN_DSKCHG];

		// The timer starts from the raw button edge, never from the status latch.
		target = (12'(stateReg.delaySel) + 12'h001) * 12'(TICKS_PER_STEP);
		stateNext.powerOff = 1'b0;
		case (stateReg.tmr)
			PMIRQ_TMR_IDLE:
			begin
				stateNext.tickCnt = '0;
				stateNext.stepCnt = 12'h000;
				if (buttonEv & stateReg.ctrl[`PMIRQ_CT_OFF_EN]
					& stateReg.ctrl[`PMIRQ_CT_POWEROFF_DELAY_OPTION])
					stateNext.tmr = PMIRQ_TMR_RUN;
			end
			PMIRQ_TMR_RUN:
			begin
				if (stateReg.tickCnt == TW'(TICK_CYCLES - 1))
				begin
					stateNext.tickCnt = '0;
					stateNext.stepCnt = stateReg.stepCnt + 12'h001;
					if (stateReg.stepCnt + 12'h001 == target)
					begin
						stateNext.tmr = PMIRQ_TMR_IDLE;
						stateNext.powerOff = 1'b1;
					end
				end
				else
					stateNext.tickCnt = stateReg.tickCnt + TW'(1);
			end
			default:
				stateNext.tmr = PMIRQ_TMR_IDLE;
		endcase

		stateNext.powerOn = events[`PMIRQ_ST_RING] & stateReg.ctrl[`PMIRQ_CT_RING_WAKE];

		// Routing outputs; the parallel bit leaves control and management routing alone.
		stateNext.serEn = ~stateReg.route[`PMIRQ_RT_PARALLEL];
		stateNext.biosEn = ~stateReg.route[`PMIRQ_RT_PARALLEL];
		stateNext.irq15Pin = stateReg.route[`PMIRQ_RT_PARALLEL]
			? padDrive(irq15Request, 1'b1, 1'b0) : 2'b01;
		stateNext.irq14Pin = stateReg.route[`PMIRQ_RT_PARALLEL]
			? padDrive(irq14Request, 1'b1, 1'b0) : 2'b01;
		stateNext.sciSer = sciRequest & ~stateReg.route[`PMIRQ_RT_SCI_PIN];
		stateNext.smiSer = smiRequest & ~stateReg.route[`PMIRQ_RT_SMI_PIN];
		stateNext.smiPin = stateReg.route[`PMIRQ_RT_SMI_PIN]
			? padDrive(smiRequest, stateReg.ctrl[`PMIRQ_CT_SMI_POL],
				~stateReg.ctrl[`PMIRQ_CT_SMI_PP]) : 2'b01;
		sharedSel = pmirq_shared_e'(stateReg.route[`PMIRQ_RT_SHARED_HI:`PMIRQ_RT_SHARED_LO]);
		stateNext.sciOvr = stateReg.route[`PMIRQ_RT_SHARED_LO];
		stateNext.sciNum = stateReg.route[`PMIRQ_RT_SHARED_LO] ? 4'h0 : sciConfigIrq;
		stateNext.sciPin = (stateReg.route[`PMIRQ_RT_SCI_PIN] & ~stateReg.route[`PMIRQ_RT_SHARED_LO])
			? padDrive(sciRequest, stateReg.route[`PMIRQ_RT_SCI_POL],
				stateReg.route[`PMIRQ_RT_SCI_OD]) : 2'b01;
		case (sharedSel)
			PMIRQ_SHARED_PME:
				stateNext.shared = padDrive(pmeRequest, 1'b0, 1'b1);
			PMIRQ_SHARED_SCI:
				stateNext.shared = padDrive(sciRequest & stateReg.route[`PMIRQ_RT_SCI_PIN],
					stateReg.route[`PMIRQ_RT_SCI_POL],
					stateReg.route[`PMIRQ_RT_SCI_OD]);
			PMIRQ_SHARED_IRQ9:
				stateNext.shared = padDrive(irq9Request, 1'b1, 1'b0);
			default:
				stateNext.shared = 2'b01;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			stateReg <= '0;
			stateReg.delaySel <= `PMIRQ_RST_DELAY;
			stateReg.route <= `PMIRQ_RST_ROUTE;
			stateReg.forceBits <= `PMIRQ_RST_FORCE;
			stateReg.ctrl <= `PMIRQ_RST_CTRL;
			stateReg.tmr <= PMIRQ_TMR_IDLE;
			stateReg.sync1 <= `PMIRQ_RST_PINS;
			stateReg.sync2 <= `PMIRQ_RST_PINS;
			stateReg.prev <= `PMIRQ_RST_PINS;
			stateReg.biosEn <= 1'b1;
			stateReg.serEn <= 1'b1;
			stateReg.shared <= 2'b01;
			stateReg.sciPin <= 2'b01;
			stateReg.smiPin <= 2'b01;
			stateReg.irq15Pin <= 2'b01;
			stateReg.irq14Pin <= 2'b01;
		end
		else
			stateReg <= stateNext;
	end

	assign wb_ack_o = stateReg.ack;
	assign wb_dat_o = {24'h000000, stateReg.dat};
	assign powerOnOutput = stateReg.powerOn;
	assign powerOffRequest = stateReg.powerOff;
	assign diskChangeFlag = stateReg.dskChg;
	assign forceDiskChange = stateReg.forceBits;
	assign biosBufferEnable = stateReg.biosEn;
	assign serialIrqEnable = stateReg.serEn;
	assign sciSerialRequest = stateReg.sciSer;
	assign smiSerialRequest = stateReg.smiSer;
	assign sciIrqOverride = stateReg.sciOvr;
	assign sciIrqNumber = stateReg.sciNum;
	assign sharedPinOut = stateReg.shared[1];
	assign sharedPinOe_n = stateReg.shared[0];
	assign sciIrqPinOut = stateReg.sciPin[1];
	assign sciIrqPinOe_n = stateReg.sciPin[0];
	assign managementInterruptPinOut = stateReg.smiPin[1];
	assign managementInterruptPinOe_n = stateReg.smiPin[0];
	assign irq15PinOut = stateReg.irq15Pin[1];
	assign irq15PinOe_n = stateReg.irq15Pin[0];
	assign irq14PinOut = stateReg.irq14Pin[1];
	assign irq14PinOe_n = stateReg.irq14Pin[0];
endmodule : pmirq_runtime_regs
`default_nettype wire

// [pmirq_runtime_regs_asserts.sv]
// Purpose: Port-level checks of the runtime register bank.
// Assumes: Sees only top-level ports; one clock domain.
// Notes: Bus timing checks carry no tag.
`timescale 1ns/100ps
`default_nettype none
module pmirq_runtime_regs_asserts
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        biosBufferEnable,
	input wire logic        serialIrqEnable,
	input wire logic        sciIrqOverride,
	input wire logic [3:0]  sciIrqNumber,
	input wire logic [1:0]  forceDiskChange,
	input wire logic        powerOffRequest,
	input wire logic        powerOnOutput
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held too long");
	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
	property p_upper_zero;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes not zero");
	property p_bios;
		biosBufferEnable == serialIrqEnable;
	endproperty
	a_bios: assert property (p_bios) else $error("buffer and serial mode disagree");
	property p_override;
		sciIrqOverride |-> sciIrqNumber == 4'h0;
	endproperty
	a_override: assert property (p_override) else $error("override kept irq number");
	// Force bits may only rise from a written one, so a lost step clear shows elsewhere.
	property p_force_set;
		!$past(wb_ack_o && wb_we_i) |-> (forceDiskChange & ~$past(forceDiskChange)) == 2'h0;
	endproperty
	a_force_set: assert property (p_force_set) else $error("force bit set without write");
	property p_off_pulse;
		powerOffRequest |=> !powerOffRequest;
	endproperty
	a_off_pulse: assert property (p_off_pulse) else $error("power-off pulse too long");
	property p_on_pulse;
		powerOnOutput |=> !powerOnOutput;
	endproperty
	a_on_pulse: assert property (p_on_pulse) else $error("power-on pulse too long");
	c_write: cover property (wb_ack_o && wb_we_i);
	c_off: cover property (powerOffRequest);
	c_over: cover property (sciIrqOverride);
endmodule : pmirq_runtime_regs_asserts
bind pmirq_runtime_regs pmirq_runtime_regs_asserts u_asserts (.ref_clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .biosBufferEnable, .serialIrqEnable,
	.sciIrqOverride, .sciIrqNumber, .forceDiskChange, .powerOffRequest, .powerOnOutput);
`default_nettype wire

// [pmirq_runtime_regs_bench.sv]
// Purpose: Self-checking bench for the runtime register bank.
// Assumes: Short timer counts of four cycles a tick and two ticks a step.
// Notes: Pin events are given eight cycles to cross the synchronisers.
`include "pmirq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module pmirq_runtime_regs_bench;
	logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [`PMIRQ_ADR_W-1:0] wb_adr_i;
	logic [3:0] wb_sel_i, sciConfigIrq, sciIrqNumber, pins, fl;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic sciRequest, smiRequest, pmeRequest, irq9Request, irq14Request, irq15Request;
	logic powerOnOutput, powerOffRequest, diskChangeFlag, biosBufferEnable, serialIrqEnable;
	logic sciSerialRequest, smiSerialRequest, sciIrqOverride, sharedPinOut, sharedPinOe_n;
	logic sciIrqPinOut, sciIrqPinOe_n, managementInterruptPinOut, managementInterruptPinOe_n;
	logic irq15PinOut, irq15PinOe_n, irq14PinOut, irq14PinOe_n;
	logic [1:0] forceDiskChange;
	logic [7:0] rv [7] = '{8'h00, 8'h40, 8'h2C, 8'h34, 8'h60, 8'h83, 8'h0C};
	logic [1:0] sh [7] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b01, 2'b00, 2'b00};
	logic [1:0] sp [7] = '{2'b01, 2'b01, 2'b01, 2'b01, 2'b01, 2'b01, 2'b10};
	int fail_count, checks_done, i, n, onCount;
	pmirq_host_model u_host (.ref_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	pmirq_runtime_regs #(.TICK_CYCLES(4), .TICKS_PER_STEP(2)) u_dut (.ref_clk, .rst, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.uart1ReceivePin(pins[0]), .uart2ReceivePin(pins[1]), .powerButtonPin_n(pins[2]),
		.ringIndicatePin_n(pins[3]), .floppyStepSignal(fl[0]), .driveSelectZero(fl[1]),
		.driveSelectOne(fl[2]), .diskChangeInput(fl[3]), .sciRequest, .smiRequest, .pmeRequest,
		.irq9Request, .irq14Request, .irq15Request, .sciConfigIrq, .powerOnOutput,
		.powerOffRequest, .diskChangeFlag, .forceDiskChange, .biosBufferEnable, .serialIrqEnable,
		.sciSerialRequest, .smiSerialRequest, .sciIrqOverride, .sciIrqNumber, .sharedPinOut,
		.sharedPinOe_n, .sciIrqPinOut, .sciIrqPinOe_n, .managementInterruptPinOut,
		.managementInterruptPinOe_n, .irq15PinOut, .irq15PinOe_n, .irq14PinOut, .irq14PinOe_n);
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// The wake output is a single-cycle pulse, so it is counted rather than polled.
	always @(posedge ref_clk)
	begin
		if (powerOnOutput === 1'b1)
			onCount++;
	end
	task automatic w(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : w
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		u_host.xfer(1'b1, idx, d, q);
	endtask : wr
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp, input string what);
		logic [31:0] q;
		u_host.xfer(1'b0, idx, 8'h00, q);
		chk(q, {24'h000000, exp}, what);
	endtask : rc
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// A hang anywhere in the sequence ends here rather than running forever.
	initial
	begin
		w(20000);
		fail_count++;
		final_report();
	end
	initial
	begin
		rst = 1'b1;
		pins = 4'hF;
		fl = 4'h0;
		sciConfigIrq = 4'h5;
		{sciRequest, smiRequest, pmeRequest, irq9Request, irq14Request, irq15Request} = 6'h00;
		w(16);
		rst <= 1'b0;
		rc(`PMIRQ_IDX_DELAY, 8'h00, "delay reset");
		rc(`PMIRQ_IDX_ROUTE, 8'h00, "route reset");
		rc(`PMIRQ_IDX_FORCE, 8'h03, "force reset");
		rc(`PMIRQ_IDX_STATUS2, 8'h00, "status reset");
		rc(8'hFF, 8'h00, "unmapped");
		wr(`PMIRQ_IDX_DELAY, 8'hFF);
		rc(`PMIRQ_IDX_DELAY, 8'h3F, "delay mask");
		wr(`PMIRQ_IDX_CTRL, 8'h11);
		for (i = 0; i < 4; i++)
		begin
			pins[i] <= 1'b0;
			w(8);
			rc(`PMIRQ_IDX_STATUS2, 8'h01 << i, "status set");
			pins[i] <= 1'b1;
			rc(`PMIRQ_IDX_STATUS2, 8'h00, "status clear");
		end
		chk(onCount, 32'd1, "ring wake pulse");
		{sciRequest, smiRequest, pmeRequest, irq9Request, irq14Request, irq15Request} <= 6'h3F;
		for (i = 0; i < 7; i++)
		begin
			wr(`PMIRQ_IDX_ROUTE, rv[i]);
			w(2);
			chk({sharedPinOut, sharedPinOe_n}, sh[i], "shared pin");
			chk({serialIrqEnable, sciSerialRequest}, {~rv[i][0], ~rv[i][2]}, "serial");
			chk({sciIrqPinOut, sciIrqPinOe_n}, sp[i], "sci pin");
			chk({irq15PinOut, irq15PinOe_n, irq14PinOut, irq14PinOe_n},
				rv[i][0] ? 4'hA : 4'h5, "parallel pins");
			chk({biosBufferEnable, smiSerialRequest, sciIrqOverride},
				{~rv[i][0], ~rv[i][7], rv[i][5]}, "routing");
			chk({managementInterruptPinOut, managementInterruptPinOe_n},
				rv[i][7] ? 2'b00 : 2'b01, "smi pin");
			chk(sciIrqNumber, rv[i][5] ? 4'h0 : 4'h5, "sci number");
			rc(`PMIRQ_IDX_ROUTE, rv[i] & 8'hFD, "route read");
		end
		wr(`PMIRQ_IDX_ROUTE, 8'h00);
		fl <= 4'b0010;
		w(6);
		chk(diskChangeFlag, 1'b1, "forced change 0");
		fl <= 4'b0011;
		w(6);
		fl <= 4'b0000;
		rc(`PMIRQ_IDX_FORCE, 8'h02, "step clears 0");
		w(6);
		chk(diskChangeFlag, 1'b0, "change idle");
		wr(`PMIRQ_IDX_FORCE, 8'h00);
		rc(`PMIRQ_IDX_FORCE, 8'h02, "no soft clear");
		wr(`PMIRQ_IDX_FORCE, 8'h01);
		rc(`PMIRQ_IDX_FORCE, 8'h03, "soft set");
		fl <= 4'b0101;
		w(6);
		fl <= 4'b0000;
		rc(`PMIRQ_IDX_FORCE, 8'h01, "step clears 1");
		chk(forceDiskChange, 2'h1, "force port");
		fl <= 4'b1000;
		w(6);
		chk(diskChangeFlag, 1'b1, "change input");
		fl <= 4'b0000;
		// Option bit set now, so a press starts the power-off delay.
		wr(`PMIRQ_IDX_CTRL, 8'h03);
		for (i = 0; i < 2; i++)
		begin
			wr(`PMIRQ_IDX_DELAY, 8'(i * 3));
			pins[2] <= 1'b0;
			n = 0;
			do
			begin
				@(negedge ref_clk);
				n++;
			end while (powerOffRequest !== 1'b1 && n < 1000);
			// Allowed span is nominal to nominal plus one tick of four cycles.
			chk((n - 1) inside {[(i * 3 + 1) * 8 : (i * 3 + 1) * 8 + 4]}, 1'b1, "delay");
			@(posedge ref_clk);
			pins[2] <= 1'b1;
			w(4);
		end
		final_report();
	end
endmodule : pmirq_runtime_regs_bench
`default_nettype wire
